// ---- src/dcc_pkg.sv ----
package dcc_pkg;
   // register addresses on the plain software port
   localparam logic [2:0] addr_zero_control = 3'h0;
   localparam logic [2:0] addr_zero_input_select = 3'h1;
   localparam logic [2:0] addr_zero_mode = 3'h2;
   localparam logic [2:0] addr_one_control = 3'h3;
   localparam logic [2:0] addr_one_input_select = 3'h4;
   localparam logic [2:0] addr_one_mode = 3'h5;
   localparam logic [2:0] addr_reset_source = 3'h6;
   // control register field positions
   localparam int ctl_on_bit = 7;
   localparam int ctl_state_bit = 6;
   localparam int ctl_rise_bit = 5;
   localparam int ctl_fall_bit = 4;
   localparam int ctl_pos_hyst_lsb = 2;
   localparam int ctl_neg_hyst_lsb = 0;
   // mode register field positions
   localparam int mode_rise_ie_bit = 5;
   localparam int mode_fall_ie_bit = 4;
   localparam int mode_resp_lsb = 0;
   // input select field positions
   localparam int mux_neg_lsb = 4;
   localparam int mux_pos_lsb = 0;
   // reset values
   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [7:0] mode_reset = 8'h02;
   localparam logic [7:0] input_select_reset = 8'hff;
   localparam logic [7:0] input_select_unused = 8'hcc;
   localparam logic [7:0] mode_writable = 8'h33;
   localparam logic [7:0] control_writable = 8'hbf;
   localparam logic reset_source_reset = 1'b0;
   // number of comparators
   localparam int num_cmp = 2;

   // per-comparator settings forwarded to the analog core
   typedef struct packed {
      logic on;
      logic [1:0] pos_input_select;
      logic [1:0] neg_input_select;
      logic [1:0] pos_hyst;
      logic [1:0] neg_hyst;
      logic [1:0] response_mode;
   } dcc_analog_cfg_t;

   // per-comparator software state
   typedef struct packed {
      logic on;
      logic rise_flag;
      logic fall_flag;
      logic [1:0] pos_hyst;
      logic [1:0] neg_hyst;
      logic rise_irq_en;
      logic fall_irq_en;
      logic [1:0] response_mode;
      logic [1:0] pos_input_select;
      logic [1:0] neg_input_select;
   } dcc_cmp_regs_t;

   typedef enum logic [2:0] {
      dcc_st_off = 3'b001,
      dcc_st_settle = 3'b010,
      dcc_st_run = 3'b100
   } dcc_state_t;
endpackage

// ---- src/dcc_sync3.sv ----
`timescale 1ns/1ns
// three-stage pin synchroniser; change accepted when stages two and three agree
module dcc_sync3 (
   input wire logic clk,
   input wire logic rstn,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_sync_out;

   // stage one feeds only stage two; the filter looks at two and three
   always_comb begin
      next_stage = {stage[1:0], async_in};
      next_sync_out = sync_out;
      if (stage[1] == stage[2]) begin
         next_sync_out = stage[2];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage <= 3'h0;
         sync_out <= 1'b0;
      end else begin
         stage <= next_stage;
         sync_out <= next_sync_out;
      end
   end
endmodule

// ---- src/dcc_top.sv ----
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dcc_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] cmp_analog_out,
   output dcc_pkg::dcc_analog_cfg_t cmp_zero_cfg,
   output dcc_pkg::dcc_analog_cfg_t cmp_one_cfg,
   output logic cmp_zero_sync_out,
   output logic cmp_one_sync_out,
   output logic cmp_zero_raw_out,
   output logic cmp_one_raw_out,
   output logic cmp_zero_irq,
   output logic cmp_one_irq,
   output logic cmp_zero_reset_req
);
   dcc_pkg::dcc_cmp_regs_t regs [2];
   dcc_pkg::dcc_cmp_regs_t next_regs [2];
   logic [1:0] synced;
   logic [1:0] prev;
   logic [1:0] next_prev;
   logic [1:0] rise_evt;
   logic [1:0] fall_evt;
   logic reset_source_en;
   logic next_reset_source_en;
   logic [7:0] next_reg_rdata;

   // control register image for one comparator
   function automatic logic [7:0] ctl_image(input dcc_pkg::dcc_cmp_regs_t r,
                                            input logic state);
      logic [7:0] v;
      v = 8'h00;
      v[dcc_pkg::ctl_on_bit] = r.on;
      v[dcc_pkg::ctl_state_bit] = state;
      v[dcc_pkg::ctl_rise_bit] = r.rise_flag;
      v[dcc_pkg::ctl_fall_bit] = r.fall_flag;
      v[dcc_pkg::ctl_pos_hyst_lsb +: 2] = r.pos_hyst;
      v[dcc_pkg::ctl_neg_hyst_lsb +: 2] = r.neg_hyst;
      return v;
   endfunction

   // mode register image; unused bits read zero
   function automatic logic [7:0] mode_image(input dcc_pkg::dcc_cmp_regs_t r);
      logic [7:0] v;
      v = 8'h00;
      v[dcc_pkg::mode_rise_ie_bit] = r.rise_irq_en;
      v[dcc_pkg::mode_fall_ie_bit] = r.fall_irq_en;
      v[dcc_pkg::mode_resp_lsb +: 2] = r.response_mode;
      return v;
   endfunction

   // input select image; unused bits always read one
   function automatic logic [7:0] mux_image(input dcc_pkg::dcc_cmp_regs_t r);
      logic [7:0] v;
      v = dcc_pkg::input_select_unused;
      v[dcc_pkg::mux_neg_lsb +: 2] = r.neg_input_select;
      v[dcc_pkg::mux_pos_lsb +: 2] = r.pos_input_select;
      return v;
   endfunction

   // forwarded analog settings
   function automatic dcc_pkg::dcc_analog_cfg_t cfg_of(
      input dcc_pkg::dcc_cmp_regs_t r);
      dcc_pkg::dcc_analog_cfg_t c;
      c.on = r.on;
      c.pos_input_select = r.pos_input_select;
      c.neg_input_select = r.neg_input_select;
      c.pos_hyst = r.pos_hyst;
      c.neg_hyst = r.neg_hyst;
      c.response_mode = r.response_mode;
      return c;
   endfunction

   // per-comparator register addresses for the write decode
   function automatic logic [2:0] ctl_addr_of(input int i);
      return (i == 0) ? dcc_pkg::addr_zero_control
                      : dcc_pkg::addr_one_control;
   endfunction

   function automatic logic [2:0] mux_addr_of(input int i);
      return (i == 0) ? dcc_pkg::addr_zero_input_select
                      : dcc_pkg::addr_one_input_select;
   endfunction

   function automatic logic [2:0] mode_addr_of(input int i);
      return (i == 0) ? dcc_pkg::addr_zero_mode
                      : dcc_pkg::addr_one_mode;
   endfunction

   // write strobe aimed at one register address
   function automatic logic wr_hit(input logic wr,
                                   input logic [2:0] addr,
                                   input logic [2:0] target);
      return wr && addr == target;
   endfunction

   // sticky flag: a hardware set beats a software write in one cycle,
   // so an edge that lands on the clearing write is never lost
   function automatic logic flag_next(input logic cur,
                                      input logic hit,
                                      input logic wbit,
                                      input logic set);
      logic v;
      v = cur;
      if (hit) begin
         v = wbit;
      end
      if (set) begin
         v = 1'b1;
      end
      return v;
   endfunction

   // pin synchronisers; the raw analog level is not clock-aligned
   dcc_sync3 u_sync_zero (
      .clk(clk),
      .rstn(rstn),
      .async_in(cmp_analog_out[0]),
      .sync_out(synced[0])
   );
   dcc_sync3 u_sync_one (
      .clk(clk),
      .rstn(rstn),
      .async_in(cmp_analog_out[1]),
      .sync_out(synced[1])
   );

   // edge detection on the synchronised level, gated by enable
   // the analog core may glitch while off, so edges count only when on
   always_comb begin
      for (int i = 0; i < dcc_pkg::num_cmp; i++) begin
         rise_evt[i] = regs[i].on && synced[i] && !prev[i];
         fall_evt[i] = regs[i].on && !synced[i] && prev[i];
      end
      next_prev = synced;
   end

   // register writes, then hardware sets win over software clears
   always_comb begin
      logic [2:0] a_ctl;
      logic [2:0] a_mux;
      logic [2:0] a_mode;
      next_regs = regs;
      next_reset_source_en = reset_source_en;
      a_ctl = 3'h0;
      a_mux = 3'h0;
      a_mode = 3'h0;
      for (int i = 0; i < dcc_pkg::num_cmp; i++) begin
         a_ctl = ctl_addr_of(i);
         a_mux = mux_addr_of(i);
         a_mode = mode_addr_of(i);
         if (wr_hit(reg_wr, reg_addr, a_ctl)) begin
            next_regs[i].on = reg_wdata[dcc_pkg::ctl_on_bit];
            next_regs[i].pos_hyst =
               reg_wdata[dcc_pkg::ctl_pos_hyst_lsb +: 2];
            next_regs[i].neg_hyst =
               reg_wdata[dcc_pkg::ctl_neg_hyst_lsb +: 2];
         end
         if (wr_hit(reg_wr, reg_addr, a_mux)) begin
            next_regs[i].pos_input_select =
               reg_wdata[dcc_pkg::mux_pos_lsb +: 2];
            next_regs[i].neg_input_select =
               reg_wdata[dcc_pkg::mux_neg_lsb +: 2];
         end
         if (wr_hit(reg_wr, reg_addr, a_mode)) begin
            next_regs[i].rise_irq_en =
               reg_wdata[dcc_pkg::mode_rise_ie_bit];
            next_regs[i].fall_irq_en =
               reg_wdata[dcc_pkg::mode_fall_ie_bit];
            next_regs[i].response_mode =
               reg_wdata[dcc_pkg::mode_resp_lsb +: 2];
         end
         // sticky set overrides a clear in the same cycle
         next_regs[i].rise_flag = flag_next(regs[i].rise_flag,
            wr_hit(reg_wr, reg_addr, a_ctl),
            reg_wdata[dcc_pkg::ctl_rise_bit], rise_evt[i]);
         next_regs[i].fall_flag = flag_next(regs[i].fall_flag,
            wr_hit(reg_wr, reg_addr, a_ctl),
            reg_wdata[dcc_pkg::ctl_fall_bit], fall_evt[i]);
      end
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::addr_reset_source)) begin
         next_reset_source_en = reg_wdata[0];
      end
   end

   // read data, valid in the cycle after the read strobe
   always_comb begin
      next_reg_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            dcc_pkg::addr_zero_control:
               next_reg_rdata = ctl_image(regs[0], synced[0]);
            dcc_pkg::addr_zero_input_select:
               next_reg_rdata = mux_image(regs[0]);
            dcc_pkg::addr_zero_mode:
               next_reg_rdata = mode_image(regs[0]);
            dcc_pkg::addr_one_control:
               next_reg_rdata = ctl_image(regs[1], synced[1]);
            dcc_pkg::addr_one_input_select:
               next_reg_rdata = mux_image(regs[1]);
            dcc_pkg::addr_one_mode:
               next_reg_rdata = mode_image(regs[1]);
            dcc_pkg::addr_reset_source:
               next_reg_rdata = {7'h00, reset_source_en};
            default:
               next_reg_rdata = 8'h00;
         endcase
      end
   end

   // software registers and the reset-source enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < dcc_pkg::num_cmp; i++) begin
            regs[i].on <= dcc_pkg::control_reset[dcc_pkg::ctl_on_bit];
            regs[i].rise_flag <= dcc_pkg::control_reset[dcc_pkg::ctl_rise_bit];
            regs[i].fall_flag <= dcc_pkg::control_reset[dcc_pkg::ctl_fall_bit];
            regs[i].pos_hyst <=
               dcc_pkg::control_reset[dcc_pkg::ctl_pos_hyst_lsb +: 2];
            regs[i].neg_hyst <=
               dcc_pkg::control_reset[dcc_pkg::ctl_neg_hyst_lsb +: 2];
            regs[i].rise_irq_en <=
               dcc_pkg::mode_reset[dcc_pkg::mode_rise_ie_bit];
            regs[i].fall_irq_en <=
               dcc_pkg::mode_reset[dcc_pkg::mode_fall_ie_bit];
            regs[i].response_mode <=
               dcc_pkg::mode_reset[dcc_pkg::mode_resp_lsb +: 2];
            regs[i].pos_input_select <=
               dcc_pkg::input_select_reset[dcc_pkg::mux_pos_lsb +: 2];
            regs[i].neg_input_select <=
               dcc_pkg::input_select_reset[dcc_pkg::mux_neg_lsb +: 2];
         end
         reset_source_en <= dcc_pkg::reset_source_reset;
      end else begin
         regs <= next_regs;
         reset_source_en <= next_reset_source_en;
      end
   end

   // previous synchronised level for the edge finder
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev <= 2'h0;
      end else begin
         prev <= next_prev;
      end
   end

   // read data stands for exactly one cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // analog settings straight from the registers
   assign cmp_zero_cfg = cfg_of(regs[0]);
   assign cmp_one_cfg = cfg_of(regs[1]);

   // pin outputs; raw path is purely combinational so it needs no clock
   // the and with the enable keeps a disabled comparator low on the pin
   assign cmp_zero_raw_out = cmp_analog_out[0] & regs[0].on;
   assign cmp_one_raw_out = cmp_analog_out[1] & regs[1].on;
   assign cmp_zero_sync_out = synced[0] & regs[0].on;
   assign cmp_one_sync_out = synced[1] & regs[1].on;

   // independent masked requests for both edge directions
   assign cmp_zero_irq = (regs[0].rise_flag & regs[0].rise_irq_en) |
                         (regs[0].fall_flag & regs[0].fall_irq_en);
   assign cmp_one_irq = (regs[1].rise_flag & regs[1].rise_irq_en) |
                        (regs[1].fall_flag & regs[1].fall_irq_en);

   // reset request: active when comparator zero is on, enabled and low
   // (the reset logic decides polarity use; offered here as a level)
   assign cmp_zero_reset_req = reset_source_en & regs[0].on &
                               ~synced[0];
endmodule

// ---- verification/dcc_monitor.sv ----
`timescale 1ns/1ns
// port-level checks beside the top module
module dcc_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] cmp_analog_out,
   input dcc_pkg::dcc_analog_cfg_t cmp_zero_cfg,
   input dcc_pkg::dcc_analog_cfg_t cmp_one_cfg,
   input wire logic cmp_zero_sync_out,
   input wire logic cmp_one_sync_out,
   input wire logic cmp_zero_raw_out,
   input wire logic cmp_one_raw_out,
   input wire logic cmp_zero_irq,
   input wire logic cmp_one_irq,
   input wire logic cmp_zero_reset_req
);
   // one clock domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // raw output is the analog level gated by the on bit
   property p_raw;
      cmp_one_raw_out == (cmp_analog_out[1] && cmp_one_cfg.on);
   endproperty
   a_raw: assert property (p_raw) else $error("raw output mismatch");
   property p_off;
      !cmp_zero_cfg.on |-> !cmp_zero_sync_out && !cmp_zero_raw_out;
   endproperty
   a_off: assert property (p_off) else $error("off output not low");
   // a long quiet low input must have reached the synced side
   property p_sync; !cmp_analog_out[0] [*6] |-> !cmp_zero_sync_out; endproperty
   a_sync: assert property (p_sync) else $error("sync output stale");
   property p_hold;
      cmp_zero_irq && !(reg_wr && (reg_addr == 3'h0 || reg_addr == 3'h2))
         |=> cmp_zero_irq;
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_unmap; reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_mux;
      reg_rd && reg_addr == 3'h4 |=> (reg_rdata & 8'hcc) == 8'hcc;
   endproperty
   a_mux: assert property (p_mux) else $error("unused select bits");
   property p_ctl;
      reg_wr && reg_addr == 3'h0 |=> cmp_zero_cfg.on == $past(reg_wdata[7])
         && {cmp_zero_cfg.pos_hyst, cmp_zero_cfg.neg_hyst}
         == $past(reg_wdata[3:0]);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control not forwarded");
   property p_rst; cmp_zero_reset_req |-> cmp_zero_cfg.on && !cmp_zero_sync_out;
   endproperty
   a_rst: assert property (p_rst) else $error("reset request wrong");
   c_irq: cover property ($rose(cmp_one_irq));
   c_rst: cover property (cmp_zero_reset_req);
   c_sync: cover property ($rose(cmp_zero_sync_out));
endmodule

// ---- verification/dcc_cmp_model.sv ----
`timescale 1ns/1ns
// analog cores: a pin bit of one stands for the higher voltage
module dcc_cmp_model (
   input dcc_pkg::dcc_analog_cfg_t cfg_zero,
   input dcc_pkg::dcc_analog_cfg_t cfg_one,
   input wire logic [7:0] pos_lvl,
   input wire logic [7:0] neg_lvl,
   output logic [1:0] analog_out
);
   // a core that is off drives low, so no edge leaks while disabled
   assign analog_out[0] = cfg_zero.on & pos_lvl[{1'b0, cfg_zero.pos_input_select}]
      & ~neg_lvl[{1'b0, cfg_zero.neg_input_select}];
   assign analog_out[1] = cfg_one.on & pos_lvl[{1'b1, cfg_one.pos_input_select}]
      & ~neg_lvl[{1'b1, cfg_one.neg_input_select}];
endmodule

// ---- verification/dcc_top_tb.sv ----
`timescale 1ns/1ns
module dcc_top_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] analog;
   logic [7:0] pos_lvl = 8'h00;
   logic [7:0] neg_lvl = 8'h00;
   dcc_pkg::dcc_analog_cfg_t cfg0;
   dcc_pkg::dcc_analog_cfg_t cfg1;
   logic [1:0] sync_o;
   logic [1:0] raw_o;
   logic [1:0] irq_o;
   logic rst_req;
   logic [7:0] rv;
   logic [2:0] b;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   logic [7:0] rst_tab [8] = '{8'h00, 8'hff, 8'h02, 8'h00, 8'hff, 8'h02, 8'h00,
      8'h00};

   always #50 clk = ~clk;

   dcc_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmp_analog_out(analog), .cmp_zero_cfg(cfg0),
      .cmp_one_cfg(cfg1), .cmp_zero_sync_out(sync_o[0]),
      .cmp_one_sync_out(sync_o[1]), .cmp_zero_raw_out(raw_o[0]),
      .cmp_one_raw_out(raw_o[1]), .cmp_zero_irq(irq_o[0]),
      .cmp_one_irq(irq_o[1]), .cmp_zero_reset_req(rst_req));
   dcc_cmp_model model (.cfg_zero(cfg0), .cfg_one(cfg1), .pos_lvl(pos_lvl),
      .neg_lvl(neg_lvl), .analog_out(analog));

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // synchroniser plus flag stage take about five edges; eight leaves margin
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], rv);
         chk("reset value", rv, rst_tab[a]);
      end
      $display("test reset values done");
      wr(dcc_pkg::addr_zero_input_select, 8'h00);
      rd(dcc_pkg::addr_zero_input_select, rv);
      chk("select mask", rv, 8'hcc);
      wr(dcc_pkg::addr_one_mode, 8'hff);
      rd(dcc_pkg::addr_one_mode, rv);
      chk("mode mask", rv, 8'h33);
      chk("response code", {6'h00, cfg1.response_mode}, 8'h03);
      wr(3'h7, 8'hff);
      rd(3'h7, rv);
      chk("unmapped", rv, 8'h00);
      for (int h = 0; h < 4; h++) begin
         wr(dcc_pkg::addr_zero_control, {4'h0, h[1:0], ~h[1:0]});
         chk("hysteresis", {4'h0, cfg0.pos_hyst, cfg0.neg_hyst},
            {4'h0, h[1:0], ~h[1:0]});
      end
      $display("test masks done");
      for (int c = 0; c < 2; c++) begin
         b = 3'(c * 3);
         wr(b + 3'h2, dcc_pkg::mode_reset);
         wr(b + 3'h1, 8'hde);
         wr(b, 8'h80);
         pos_lvl[c*4 +: 4] <= 4'b1011;
         neg_lvl[c*4 +: 4] <= 4'b1101;
         settle();
         wr(b, 8'h80);
         rd(b, rv);
         chk("low state", rv, 8'h80);
         pos_lvl[c*4+2] <= 1'b1;
         settle();
         rd(b, rv);
         chk("rise flag", rv, 8'he0);
         chk("rise masked", {7'h0, irq_o[c]}, 8'h00);
         wr(b + 3'h2, 8'h20);
         chk("rise request", {7'h0, irq_o[c]}, 8'h01);
         neg_lvl[c*4+1] <= 1'b1;
         settle();
         rd(b, rv);
         chk("fall flag", rv, 8'hb0);
         wr(b, 8'h80);
         wr(b + 3'h2, 8'h10);
         chk("cleared", {7'h0, irq_o[c]}, 8'h00);
         neg_lvl[c*4+1] <= 1'b0;
         #1 chk("raw no clock", {7'h0, raw_o[c]}, 8'h01);
         settle();
         chk("rise under fall mask", {7'h0, irq_o[c]}, 8'h00);
         chk("sync out", {7'h0, sync_o[c]}, 8'h01);
         neg_lvl[c*4+1] <= 1'b1;
         settle();
         chk("fall request", {7'h0, irq_o[c]}, 8'h01);
         neg_lvl[c*4+1] <= 1'b0;
         settle();
         wr(b, 8'h00);
         chk("off outputs", {6'h0, sync_o[c], raw_o[c]}, 8'h00);
         $display("test comparator %0d done", c);
      end
      wr(dcc_pkg::addr_reset_source, 8'h01);
      wr(dcc_pkg::addr_zero_control, 8'h80);
      settle();
      chk("no reset high", {7'h0, rst_req}, 8'h00);
      neg_lvl[1] <= 1'b1;
      settle();
      chk("reset request", {7'h0, rst_req}, 8'h01);
      wr(dcc_pkg::addr_reset_source, 8'h00);
      chk("reset source off", {7'h0, rst_req}, 8'h00);
      $display("test reset source done");
      report_and_stop();
   end
endmodule

bind dcc_top dcc_monitor mon (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cmp_analog_out(cmp_analog_out),
   .cmp_zero_cfg(cmp_zero_cfg), .cmp_one_cfg(cmp_one_cfg),
   .cmp_zero_sync_out(cmp_zero_sync_out), .cmp_one_sync_out(cmp_one_sync_out),
   .cmp_zero_raw_out(cmp_zero_raw_out), .cmp_one_raw_out(cmp_one_raw_out),
   .cmp_zero_irq(cmp_zero_irq), .cmp_one_irq(cmp_one_irq),
   .cmp_zero_reset_req(cmp_zero_reset_req));
